// ===== core/lmg_defines.vh
`ifndef LMG_DEFINES_VH
`define LMG_DEFINES_VH
// axi4-lite register byte addresses
`define LMG_ADDR_MODE 8'h00
`define LMG_ADDR_COLOR 8'h04
`define LMG_ADDR_CRTC_IDX 8'h08
`define LMG_ADDR_CRTC_DATA 8'h0c
`define LMG_ADDR_STATUS 8'h10
// mode-control bit positions
`define LMG_MODE_FAST 0
`define LMG_MODE_GFX 1
`define LMG_MODE_MONO 2
`define LMG_MODE_VIDEN 3
`define LMG_MODE_HIRES 4
`define LMG_MODE_BLINK 5
`define LMG_MODE_400 6
`define LMG_MODE_BANK 7
// colour-select bit positions
`define LMG_COL_INT 3
`define LMG_COL_FGINT 4
`define LMG_COL_PAL 5
// crt controller register numbers
`define LMG_CRTC_SA_HI 5'h0c
`define LMG_CRTC_SA_LO 5'h0d
`define LMG_CRTC_NREG 18
// geometry
`define LMG_BYTES_PER_LINE 7'd80
`define LMG_LINES 8'd200
`define LMG_ODD_BASE 16'h2000
`define LMG_PAGE_SIZE 16'h4000
`define LMG_H_TOTAL 10'd800
`define LMG_H_ACTIVE 10'd640
`define LMG_V_TOTAL 9'd440
`define LMG_V_ACTIVE 9'd400
`define LMG_HSYNC_LEN 10'd64
`define LMG_VSYNC_LEN 9'd2
`define LMG_RESP_OKAY 2'b00
`define LMG_RESP_SLVERR 2'b10
`endif

// ===== core/lmg_pixel_decoder.v
// What this block does
// - low res: 320x200, two bits per pixel
// - each pixel line scanned twice, 400 lines
// - even lines from even region base
// - odd lines from odd region 2000h
// - first byte gives four leftmost top pixels
// - upper bit red, lower bit green
// - code 00 shows colour-select background
// - palette bit drives blue gun
// - colour palettes green/red/brown, cyan/magenta/white
// - monochrome bit gives cyan/red/white palette
// - colour-select bit 4 brightens foreground
// - start address picks display page
// - mode bit 7 selects page bank
// - high res: 640x200, eight pixels per byte
// - mode-control bits decoded as listed; only bits 2, 3, 4 and 7 are used here
// - index then data reaches controller registers
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "lmg_defines.vh"
module lmg_pixel_decoder #(
    parameter H_TOTAL = 800,
    parameter V_TOTAL = 440
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    output reg [15:0] o_vram_addr,
    input wire [7:0] i_vram_data,
    output reg o_red,
    output reg o_green,
    output reg o_blue,
    output reg o_intens,
    output reg o_hsync,
    output reg o_vsync
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    reg [7:0] mode_q;
    reg [7:0] color_q;
    reg [4:0] crtc_idx_q;
    reg [7:0] crtc_q [0:`LMG_CRTC_NREG-1];
    reg [7:0] awaddr_q;
    reg aw_have_q;
    reg [7:0] wdata_q;
    reg w_have_q;
    reg wr_ok;
    integer k;
    wire vblank;

    assign o_awready = !aw_have_q && !o_bvalid;
    assign o_wready = !w_have_q && !o_bvalid;
    assign o_arready = !o_rvalid;

    // address and data are latched independently, then committed together
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            o_bvalid <= 1'b0;
            o_bresp <= `LMG_RESP_OKAY;
            mode_q <= 8'h00;
            color_q <= 8'h00;
            crtc_idx_q <= 5'h00;
            for (k = 0; k < `LMG_CRTC_NREG; k = k + 1) begin
                crtc_q[k] <= 8'h00;
            end
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= i_wstrb[0] ? i_wdata[7:0] : 8'h00;
            end
            if (aw_have_q && w_have_q) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? `LMG_RESP_OKAY : `LMG_RESP_SLVERR;
                case (awaddr_q)
                    `LMG_ADDR_MODE: mode_q <= wdata_q;
                    `LMG_ADDR_COLOR: color_q <= wdata_q;
                    `LMG_ADDR_CRTC_IDX: crtc_idx_q <= wdata_q[4:0];
                    `LMG_ADDR_CRTC_DATA: begin
                        if (crtc_idx_q < `LMG_CRTC_NREG)
                            crtc_q[crtc_idx_q] <= wdata_q;
                    end
                    default: begin
                    end
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // decode of legal write targets
    always @* begin
        case (awaddr_q)
            `LMG_ADDR_MODE, `LMG_ADDR_COLOR, `LMG_ADDR_CRTC_IDX,
            `LMG_ADDR_CRTC_DATA: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // read side: mode, colour and index read back; status shows blanking
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `LMG_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= `LMG_RESP_OKAY;
            case (i_araddr)
                `LMG_ADDR_MODE: o_rdata <= {24'h000000, mode_q};
                `LMG_ADDR_COLOR: o_rdata <= {24'h000000, color_q};
                `LMG_ADDR_CRTC_IDX: o_rdata <= {27'h0000000, crtc_idx_q};
                `LMG_ADDR_CRTC_DATA: o_rdata <= (crtc_idx_q < `LMG_CRTC_NREG) ?
                    {24'h000000, crtc_q[crtc_idx_q]} : 32'h0000_0000;
                `LMG_ADDR_STATUS: o_rdata <= {31'h0000_0000, vblank};
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= `LMG_RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // raster timing
    // ------------------------------------------------------------
    // one clock per 640-wide dot; low res pixels span two dots
    reg [9:0] hcnt_q;
    reg [8:0] vcnt_q;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hcnt_q <= 10'h000;
            vcnt_q <= 9'h000;
        end else if (hcnt_q == H_TOTAL[9:0] - 10'h001) begin
            hcnt_q <= 10'h000;
            vcnt_q <= (vcnt_q == V_TOTAL[8:0] - 9'h001) ? 9'h000 : vcnt_q + 9'h001;
        end else begin
            hcnt_q <= hcnt_q + 10'h001;
        end
    end

    wire h_act = hcnt_q < `LMG_H_ACTIVE;
    wire v_act = vcnt_q < `LMG_V_ACTIVE;
    assign vblank = !v_act;
    // pixel line is scan / 2, so each line is scanned twice
    wire [7:0] pline = vcnt_q[8:1];
    wire [6:0] bcol = hcnt_q[9:3]; // byte column, 80 per line
    // the first byte of a scan is fetched before the counter wraps, so use the next scan
    wire [8:0] vnext = (vcnt_q == V_TOTAL[8:0] - 9'h001) ? 9'h000 : vcnt_q + 9'h001;

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    // start address in words from the controller, doubled to bytes; 2000h moves to page 2
    wire [13:0] start_w = {crtc_q[`LMG_CRTC_SA_HI][5:0], crtc_q[`LMG_CRTC_SA_LO]};
    function [15:0] lmg_addr;
        input [7:0] line;
        input [6:0] col;
        input [13:0] start;
        input bank;
        reg [12:0] off;
        begin
            off = line[7:1] * `LMG_BYTES_PER_LINE + {6'h00, col};
            lmg_addr = (line[0] ? `LMG_ODD_BASE : 16'h0000)
                + {3'h0, off}
                + {1'b0, start, 1'b0}
                + (bank ? (`LMG_PAGE_SIZE << 1) : 16'h0000);
        end
    endfunction

    // fetch one byte ahead: address at dot 5, ram answers at dot 6, loaded at dot 7
    wire [6:0] next_col = bcol + 7'h01;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_vram_addr <= 16'h0000;
        end else if (hcnt_q == H_TOTAL[9:0] - 10'h003) begin
            o_vram_addr <= lmg_addr(vnext[8:1], 7'h00, start_w, mode_q[`LMG_MODE_BANK]);
        end else if (hcnt_q[2:0] == 3'h5) begin
            o_vram_addr <= lmg_addr(pline, next_col, start_w, mode_q[`LMG_MODE_BANK]);
        end
    end

    // shift register reloaded each byte; msb leaves first
    reg [7:0] shift_q;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_q <= 8'h00;
        end else if (hcnt_q[2:0] == 3'h7 || hcnt_q == H_TOTAL[9:0] - 10'h001) begin
            shift_q <= i_vram_data;
        end else if (mode_q[`LMG_MODE_HIRES]) begin
            shift_q <= {shift_q[6:0], 1'b0};
        end else if (hcnt_q[0]) begin
            shift_q <= {shift_q[5:0], 2'b00};
        end
    end

    // ------------------------------------------------------------
    // colour decode
    // ------------------------------------------------------------
    reg r_d;
    reg g_d;
    reg b_d;
    reg i_d;
    wire [1:0] code = shift_q[7:6];
    always @* begin
        r_d = 1'b0;
        g_d = 1'b0;
        b_d = 1'b0;
        i_d = 1'b0;
        if (mode_q[`LMG_MODE_HIRES]) begin
            // single-bit pixel: on is white, off is black
            r_d = shift_q[7];
            g_d = shift_q[7];
            b_d = shift_q[7];
        end else if (code == 2'b00) begin
            r_d = color_q[2];
            g_d = color_q[1];
            b_d = color_q[0];
            i_d = color_q[`LMG_COL_INT];
        end else begin
            r_d = code[1];
            g_d = code[0];
            b_d = color_q[`LMG_COL_PAL];
            if (mode_q[`LMG_MODE_MONO])
                b_d = code[0];
            i_d = color_q[`LMG_COL_FGINT];
        end
    end

    // blanking, enable and syncs are registered for clean outputs
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_red <= 1'b0;
            o_green <= 1'b0;
            o_blue <= 1'b0;
            o_intens <= 1'b0;
            o_hsync <= 1'b0;
            o_vsync <= 1'b0;
        end else begin
            o_red <= r_d & h_act & v_act & mode_q[`LMG_MODE_VIDEN];
            o_green <= g_d & h_act & v_act & mode_q[`LMG_MODE_VIDEN];
            o_blue <= b_d & h_act & v_act & mode_q[`LMG_MODE_VIDEN];
            o_intens <= i_d & h_act & v_act & mode_q[`LMG_MODE_VIDEN];
            // syncs sit at the end of the line and frame so a short raster still has them
            o_hsync <= hcnt_q >= H_TOTAL[9:0] - `LMG_HSYNC_LEN;
            o_vsync <= vcnt_q >= V_TOTAL[8:0] - `LMG_VSYNC_LEN;
        end
    end
endmodule

// ===== tb/lmg_vram_model.sv
`timescale 1ns/1ps
// ----------------------------------
// video memory seen by the decoder
// ----------------------------------
module lmg_vram_model (
    input wire i_clk,
    input wire [15:0] i_addr,
    input wire [7:0] i_fill,
    output reg [7:0] o_data
);
    // every location holds one fill byte, so colour checks need no pixel alignment;
    // the address itself is judged by the bench, one-cycle synchronous read
    always @(posedge i_clk) begin
        o_data <= i_fill | (i_addr[0] & 1'b0);
    end
endmodule

// ===== tb/lmg_pixel_decoder_assertions.sv
`timescale 1ns/1ps
module lmg_checker #(
    parameter H_TOTAL = 800
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire [1:0] o_bresp,
    input wire o_bvalid,
    input wire i_bready,
    input wire i_arvalid,
    input wire o_arready,
    input wire [31:0] o_rdata,
    input wire o_rvalid,
    input wire i_rready,
    input wire o_hsync
);
    // ---------------------------
    // bus and raster properties
    // ---------------------------
    localparam int HT = H_TOTAL;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    read_lat_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    write_lat_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("write answer late");
    bresp_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write response repeated");
    read_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("second read taken");
    write_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("second write taken");
    rdata_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    line_period_a: assert property ($rose(o_hsync) |-> ##HT $rose(o_hsync))
        else $error("line period wrong");
    write_c: cover property (o_bvalid && i_bready);
    read_c: cover property (o_rvalid && i_rready);
    line_c: cover property ($rose(o_hsync));
endmodule
bind lmg_pixel_decoder lmg_checker #(.H_TOTAL(H_TOTAL)) u_chk (.*);

// ===== tb/tb_lmg_pixel_decoder.sv
`timescale 1ns/1ps
`include "lmg_defines.vh"
module tb_lmg_pixel_decoder;
    // ------------------------------
    // bench for the pixel decoder
    // ------------------------------
    localparam int HT = 80;
    localparam int VT = 20;
    localparam int FR = HT * VT;
    reg i_clk = 0, i_rst_n = 0;
    reg [7:0] i_awaddr = 0, i_araddr = 0, fill = 0;
    reg [31:0] i_wdata = 0;
    reg [3:0] i_wstrb = 0;
    reg i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_hsync, o_vsync;
    wire o_red, o_green, o_blue, o_intens;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire [15:0] o_vram_addr;
    wire [7:0] i_vram_data;
    int failures = 0, num_checks = 0;
    lmg_pixel_decoder #(.H_TOTAL(HT), .V_TOTAL(VT)) dut (.*);
    lmg_vram_model u_mem (.i_clk(i_clk), .i_addr(o_vram_addr), .i_fill(fill), .o_data(i_vram_data));
    initial forever #2.5 i_clk = ~i_clk;
    task check(input [31:0] seen, input [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // address and data offered together, each released once taken
    task axi_wr(input [7:0] a, input [7:0] d, input [1:0] er);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_wstrb <= 4'h1;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) begin
                i_bready <= 1'b0;
                check(o_bresp, er);
                break;
            end
        end
    endtask
    task axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) begin
                i_rready <= 1'b0;
                check(o_rresp, er);
                check(o_rdata, ed);
                break;
            end
        end
    endtask
    // skip one frame to settle, then judge every cycle of the next one
    task frame(input [3:0] exp, input [15:0] lo);
        reg [3:0] g;
        reg [15:0] a;
        reg hit, ev, od, hp;
        int hr, vs;
        hit = 0;
        ev = 0;
        od = 0;
        hr = 0;
        vs = 0;
        repeat (FR) @(posedge i_clk);
        hp = o_hsync;
        repeat (FR) begin
            @(posedge i_clk);
            if (o_hsync && !hp) hr++;
            hp = o_hsync;
            if (o_vsync) vs++;
            g = {o_red, o_green, o_blue, o_intens};
            a = o_vram_addr - lo;
            if (g !== 4'h0 && g !== exp) check(g, exp);
            if (g === exp) hit = 1;
            if (a > 16'h3fff || a[12:0] >= 13'h1f40) check(a, lo);
            if (a < 16'h2000) ev = 1;
            else od = 1;
        end
        check(hit, 1);
        check({ev, od}, 2'b11);
        check(hr, VT);
        check(vs, 2 * HT);
    endtask
    task test_bus;
        reg [79:0] tv;
        int k;
        tv = 80'h34_28_2c_05_6b_00_64_64_00_03;
        for (k = 0; k < 10; k++) begin
            axi_wr(`LMG_ADDR_CRTC_IDX, k[7:0], `LMG_RESP_OKAY);
            axi_wr(`LMG_ADDR_CRTC_DATA, tv[79 - 8 * k -: 8], `LMG_RESP_OKAY);
        end
        axi_rd(`LMG_ADDR_CRTC_IDX, 32'h9, `LMG_RESP_OKAY);
        axi_rd(`LMG_ADDR_CRTC_DATA, 32'h3, `LMG_RESP_OKAY);
        axi_rd(`LMG_ADDR_MODE, 32'h0, `LMG_RESP_OKAY);
        axi_wr(8'h24, 8'hff, `LMG_RESP_SLVERR);
        axi_rd(8'h20, 32'h0, `LMG_RESP_SLVERR);
        axi_rd(`LMG_ADDR_STATUS, 32'h0, `LMG_RESP_OKAY);
    endtask
    // entries: mode, colour select, fill byte, expected red green blue intensity
    task test_colours;
        reg [27:0] t [14];
        int k;
        t = '{28'h0a00554, 28'h0a00aa8, 28'h0a00ffc, 28'h0a20556, 28'h0a20aaa, 28'h0a30fff,
              28'h0e00556, 28'h0e20aa8, 28'h0e20ffe, 28'h0a0d00b, 28'h0a1600c, 28'h1e00ffe,
              28'h023fff0, 28'h0a00000};
        for (k = 0; k < 14; k++) begin
            fill <= t[k][11:4];
            axi_wr(`LMG_ADDR_MODE, t[k][27:20], `LMG_RESP_OKAY);
            axi_wr(`LMG_ADDR_COLOR, t[k][19:12], `LMG_RESP_OKAY);
            axi_rd(`LMG_ADDR_COLOR, {24'h0, t[k][19:12]}, `LMG_RESP_OKAY);
            frame(t[k][3:0], 16'h0);
        end
    endtask
    // start address picks page two, mode bit 7 the upper bank
    task test_pages;
        int p;
        fill <= 8'h55;
        for (p = 1; p < 4; p++) begin
            axi_wr(`LMG_ADDR_CRTC_IDX, 8'h0c, `LMG_RESP_OKAY);
            axi_wr(`LMG_ADDR_CRTC_DATA, p[0] ? 8'h20 : 8'h00, `LMG_RESP_OKAY);
            axi_wr(`LMG_ADDR_MODE, p[1] ? 8'h8a : 8'h0a, `LMG_RESP_OKAY);
            frame(4'h4, p * 16'h4000);
        end
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        test_bus();
        test_colours();
        test_pages();
        give_verdict();
    end
    // a hang costs one mismatch and ends the run the normal way
    initial begin
        repeat (90000) @(posedge i_clk);
        failures++;
        give_verdict();
    end
endmodule
